// ---- shared/standby_sleep_defs.svh ----
// Timing and encoding constants for the standby/sleep inhibit sequencer
`ifndef STANDBY_SLEEP_DEFS_SVH
`define STANDBY_SLEEP_DEFS_SVH

`define CLOCK_HZ          25000000
`define SLEEP_TIMEOUT_MS  250
// Typical timeout as clock cycles at the system clock
`define SLEEP_TIMEOUT_CYC ((`CLOCK_HZ / 1000) * `SLEEP_TIMEOUT_MS)
`define TICK_DIV_DEFAULT  25000
// Timebase tick is 1 ms, so the sleep timer counts milliseconds
`define SLEEP_TICKS       `SLEEP_TIMEOUT_MS
`define WAKE_FILTER_TICKS 2
`define MODE_SLEEP        2'h0

`endif

// ---- shared/standby_sleep_pkg.sv ----
// Types for the standby/sleep inhibit sequencer
`default_nettype none
package standby_sleep_pkg;

   typedef enum logic [1:0] {
      SLEEP,
      STANDBY,
      ACTIVE,
      SLEEP_PEND
   } power_state_type;

   typedef struct packed {
      logic mode_select_hi;
      logic mode_select_lo;
   } mode_pins_type;

endpackage
`default_nettype wire

// ---- rtl/tick_divider.sv ----
// Free-running divider that yields a one-cycle timebase enable
`timescale 1ns/100ps
`default_nettype none
`include "standby_sleep_defs.svh"

module tick_divider #(
   parameter int DIVIDE = `TICK_DIV_DEFAULT
) (
   input  wire logic clock,
   input  wire logic rstn,
   output var  logic tick
);

   localparam int CW = $clog2(DIVIDE);

   logic [CW-1:0] count;
   wire           wrap = (count == CW'(DIVIDE - 1));

   always_ff @(posedge clock) begin
      if (!rstn) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= wrap ? '0 : count + CW'(1);
         tick  <= wrap;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/standby_sleep_inhibit_control.sv ----
// Power-state sequencer driving the regulator supply inhibit output
//
// Summary of operation
// - Power-on enters standby, inhibit output high.
// - No mode change in standby: sleep after 250ms.
// - Valid filtered wake-up raises inhibit, restarts standby.
// - Active mode stops timer, inhibit stays high.
// - Sleep selected, no wake: inhibit low after 250ms.
// - Leave sleep on non-zero mode or wake-up.
// - Wake-up from sleep drives wake interrupt output low.
`timescale 1ns/100ps
`default_nettype none
`include "standby_sleep_defs.svh"

module standby_sleep_inhibit_control #(
   parameter int TICK_DIV     = `TICK_DIV_DEFAULT,
   parameter int SLEEP_TICKS  = `SLEEP_TICKS,
   parameter int WAKE_TICKS   = `WAKE_FILTER_TICKS
) (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic mode_select_lo,
   input  wire logic mode_select_hi,
   input  wire logic high_voltage_wakeup,
   output var  logic supply_inhibit_out,
   output var  logic wake_interrupt_n,
   output var  logic awake
);

   // =====================================================
   // Pin synchronisers
   // =====================================================
   standby_sleep_pkg::mode_pins_type mode_s1;
   standby_sleep_pkg::mode_pins_type mode_s2;
   standby_sleep_pkg::mode_pins_type mode_s3;
   standby_sleep_pkg::mode_pins_type mode_now;
   logic [2:0] wake_sync;
   logic       wake_now;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_s1   <= '0;
         mode_s2   <= '0;
         mode_s3   <= '0;
         wake_sync <= 3'h0;
      end else begin
         mode_s1   <= '{mode_select_hi, mode_select_lo};
         mode_s2   <= mode_s1;
         mode_s3   <= mode_s2;
         wake_sync <= {wake_sync[1:0], high_voltage_wakeup};
      end
   end

   // A change is accepted only once stages two and three agree
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_now <= '0;
         wake_now <= 1'b0;
      end else begin
         if (mode_s2 == mode_s3) begin
            mode_now <= mode_s3;
         end
         if (wake_sync[1] == wake_sync[2]) begin
            wake_now <= wake_sync[2];
         end
      end
   end

   // =====================================================
   // Timebase and wake-up filter
   // =====================================================
   logic tick;

   tick_divider #(
      .DIVIDE (TICK_DIV)
   ) u_tick (
      .clock (clock),
      .rstn  (rstn),
      .tick  (tick)
   );

   localparam int TW = $clog2(SLEEP_TICKS + 1);
   localparam int FW = $clog2(WAKE_TICKS + 1);

   logic [FW-1:0] wake_count;
   // Bus traffic must persist past the filter delay to count as wake-up
   wire wake_valid = wake_now && (wake_count == FW'(WAKE_TICKS));

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wake_count <= '0;
      end else if (!wake_now) begin
         wake_count <= '0;
      end else if (tick && !wake_valid) begin
         wake_count <= wake_count + FW'(1);
      end
   end

   // =====================================================
   // Power state machine
   // =====================================================
   standby_sleep_pkg::power_state_type state;
   standby_sleep_pkg::power_state_type next_state;
   logic [TW-1:0] timer;

   wire mode_active = (mode_now != `MODE_SLEEP);
   wire timer_done  = (timer == TW'(SLEEP_TICKS));
   wire restart_timer = (next_state != state);

   always_comb begin
      next_state = state;
      case (state)
         standby_sleep_pkg::SLEEP: begin
            if (mode_active) begin
               next_state = standby_sleep_pkg::ACTIVE;
            end else if (wake_valid) begin
               next_state = standby_sleep_pkg::STANDBY;
            end
         end
         standby_sleep_pkg::STANDBY: begin
            if (mode_active) begin
               next_state = standby_sleep_pkg::ACTIVE;
            end else if (timer_done) begin
               next_state = standby_sleep_pkg::SLEEP;
            end
         end
         standby_sleep_pkg::ACTIVE: begin
            if (!mode_active) begin
               next_state = standby_sleep_pkg::SLEEP_PEND;
            end
         end
         standby_sleep_pkg::SLEEP_PEND: begin
            if (mode_active) begin
               next_state = standby_sleep_pkg::ACTIVE;
            end else if (wake_valid) begin
               next_state = standby_sleep_pkg::STANDBY;
            end else if (timer_done) begin
               next_state = standby_sleep_pkg::SLEEP;
            end
         end
         default: next_state = standby_sleep_pkg::SLEEP;
      endcase
   end

   // Timer runs only in standby and sleep-pending; stopped elsewhere
   wire timer_run = (state == standby_sleep_pkg::STANDBY) ||
                    (state == standby_sleep_pkg::SLEEP_PEND);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state <= standby_sleep_pkg::STANDBY;
         timer <= '0;
      end else begin
         state <= next_state;
         if (restart_timer || !timer_run) begin
            timer <= '0;
         end else if (tick && !timer_done) begin
            timer <= timer + TW'(1);
         end
      end
   end

   // =====================================================
   // Outputs
   // =====================================================
   wire next_inhibit = (next_state != standby_sleep_pkg::SLEEP);
   // Interrupt low while woken by bus and host has not yet chosen a mode.
   // Sleep-pending counts as asleep: the host has already asked for sleep
   // and only the supply release is still delayed.
   wire in_sleep   = (state == standby_sleep_pkg::SLEEP) ||
                     (state == standby_sleep_pkg::SLEEP_PEND);
   wire next_irq_n = !(next_state == standby_sleep_pkg::STANDBY &&
                       in_sleep) &&
                     !(state == standby_sleep_pkg::STANDBY &&
                       !wake_interrupt_n &&
                       next_state == standby_sleep_pkg::STANDBY);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         supply_inhibit_out <= 1'b1;
         wake_interrupt_n   <= 1'b1;
         awake              <= 1'b0;
      end else begin
         supply_inhibit_out <= next_inhibit;
         wake_interrupt_n   <= next_irq_n;
         awake              <= (next_state == standby_sleep_pkg::ACTIVE);
      end
   end

endmodule

`default_nettype wire

// ---- dv/host_regulator_model.sv ----
// Host and regulator model at the far side of the inhibit output
`timescale 1ns/100ps
`default_nettype none
module host_regulator_model (
   input  wire logic                             supply_inhibit_out,
   input  wire standby_sleep_pkg::mode_pins_type request,
   output var  standby_sleep_pkg::mode_pins_type pins
);
   // Unpowered host floats its pins, so the pulldowns read sleep
   assign pins = supply_inhibit_out ? request : '0;
endmodule
`default_nettype wire

// ---- dv/standby_sleep_asserts.sv ----
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module standby_sleep_asserts (
   input wire logic clock,
   input wire logic rstn,
   input wire logic mode_select_lo,
   input wire logic mode_select_hi,
   input wire logic high_voltage_wakeup,
   input wire logic supply_inhibit_out,
   input wire logic wake_interrupt_n,
   input wire logic awake
);
   logic [7:0] hiCnt;
   logic [7:0] waitCnt;
   logic [7:0] wakeCnt;
   wire        modeOn = mode_select_lo | mode_select_hi;
   wire        hiSat  = hiCnt != 8'hff;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Cycles spent powered, in sleep request, and waiting on a wake-up
   always_ff @(posedge clock) begin
      hiCnt <= (!rstn || !supply_inhibit_out) ? 8'h0 : hiCnt + {7'h0, hiSat};
      waitCnt <= (!rstn || modeOn || high_voltage_wakeup ||
                  !supply_inhibit_out) ? 8'h0 : waitCnt + 8'h1;
      wakeCnt <= (!rstn || !high_voltage_wakeup || supply_inhibit_out) ?
                 8'h0 : wakeCnt + 8'h1;
   end
   reset_state_a: assert property (disable iff (1'b0) !rstn |=>
      supply_inhibit_out && wake_interrupt_n && !awake)
      else $error("reset state wrong");
   active_keep_a: assert property (awake |-> supply_inhibit_out)
      else $error("inhibit low while active");
   mode_wake_a: assert property (modeOn [*8] |-> awake)
      else $error("active mode not taken");
   sleep_mode_a: assert property (!modeOn [*8] |-> !awake)
      else $error("awake with sleep pins");
   timeout_bound_a: assert property (waitCnt < 8'h40)
      else $error("sleep timeout too late");
   timeout_early_a: assert property ($fell(supply_inhibit_out) |->
      $past(hiCnt) > 8'h20) else $error("sleep timeout too early");
   wake_raise_a: assert property (wakeCnt < 8'h14)
      else $error("wake-up not taken");
   wake_irq_a: assert property ($rose(supply_inhibit_out) &&
      high_voltage_wakeup |-> ##[0:2] !wake_interrupt_n)
      else $error("wake interrupt missing");
   cover property ($fell(supply_inhibit_out));
   cover property ($fell(wake_interrupt_n));
   cover property ($rose(awake));
   cover property ($fell(wake_interrupt_n) && $past(supply_inhibit_out));
endmodule
`default_nettype wire
bind standby_sleep_inhibit_control standby_sleep_asserts chk_u (
   .clock(clock), .rstn(rstn), .mode_select_lo(mode_select_lo),
   .mode_select_hi(mode_select_hi),
   .high_voltage_wakeup(high_voltage_wakeup),
   .supply_inhibit_out(supply_inhibit_out),
   .wake_interrupt_n(wake_interrupt_n), .awake(awake));

// ---- dv/tb_top.sv ----
// Self-checking bench for the standby/sleep inhibit sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                             clock;
   logic                             rstn;
   logic                             wake;
   logic                             inhibit;
   logic                             irqN;
   logic                             awake;
   standby_sleep_pkg::mode_pins_type request;
   standby_sleep_pkg::mode_pins_type pins;
   int                               nErrors;
   int                               testsRun;
   int                               n;
   // Short tick and timeout keep each sleep wait near 40 cycles
   standby_sleep_inhibit_control #(.TICK_DIV(4), .SLEEP_TICKS(10),
      .WAKE_TICKS(1)) dut_u (.clock(clock), .rstn(rstn),
      .mode_select_lo(pins.mode_select_lo),
      .mode_select_hi(pins.mode_select_hi), .high_voltage_wakeup(wake),
      .supply_inhibit_out(inhibit), .wake_interrupt_n(irqN), .awake(awake));
   host_regulator_model host_u (.supply_inhibit_out(inhibit),
      .request(request), .pins(pins));
   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end
   task automatic check(input string what, input logic exp, input logic got);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic tallyAndFinish();
      if (nErrors == 0 && testsRun > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Counts falling-edge samples until inhibit (sel 0), awake (sel 1) or
   // irqN (sel 2) equals val
   task automatic waitFor(input logic [1:0] sel, input logic val,
                          input int lim);
      n = 0;
      while (((sel == 2'h2) ? irqN : sel[0] ? awake : inhibit) !== val) begin
         @(negedge clock);
         n++;
         if (n > lim) begin
            check("wait", val, ~val);
            tallyAndFinish();
         end
      end
   endtask
   task automatic powerOn();
      @(negedge clock);
      check("inhibit", 1'h1, inhibit);
      check("irqN", 1'h1, irqN);
      waitFor(2'h0, 1'h0, 80);
      check("timeout", 1'h1, n >= 32 && n <= 60);
   endtask
   task automatic wakeUp();
      @(posedge clock) wake <= 1'h1;
      waitFor(2'h0, 1'h1, 30);
      check("irqN", 1'h0, irqN);
      @(posedge clock) wake <= 1'h0;
      request <= 2'h3;
      waitFor(2'h1, 1'h1, 20);
      check("irqN", 1'h1, irqN);
   endtask
   // Sleep asked while powered, cancelled, asked again, cut by a wake-up
   task automatic pendWake();
      @(posedge clock) request <= 2'h0;
      waitFor(2'h1, 1'h0, 20);
      @(posedge clock) request <= 2'h3;
      waitFor(2'h1, 1'h1, 20);
      check("inhibit", 1'h1, inhibit);
      @(posedge clock) request <= 2'h0;
      waitFor(2'h1, 1'h0, 20);
      @(posedge clock) wake <= 1'h1;
      waitFor(2'h2, 1'h0, 20);
      check("inhibit", 1'h1, inhibit);
      @(posedge clock) wake <= 1'h0;
      waitFor(2'h0, 1'h0, 80);
      check("restart", 1'h1, n >= 28 && n <= 60);
      check("irqN", 1'h1, irqN);
   endtask
   task automatic modeSweep();
      for (int m = 1; m < 4; m++) begin
         @(posedge clock) request <= m[1:0];
         repeat (60) @(negedge clock);
         check("inhibit", 1'h1, inhibit);
         check("awake", 1'h1, awake);
      end
      @(posedge clock) request <= 2'h0;
      waitFor(2'h1, 1'h0, 20);
      waitFor(2'h0, 1'h0, 80);
      check("pending", 1'h1, n >= 28);
   endtask
   task automatic midReset();
      @(posedge clock) rstn <= 1'h0;
      repeat (3) @(negedge clock);
      check("inhibit", 1'h1, inhibit);
      check("awake", 1'h0, awake);
      @(posedge clock) rstn <= 1'h1;
      waitFor(2'h0, 1'h0, 80);
      check("timeout", 1'h1, n >= 32);
   endtask
   initial begin
      rstn = 1'h0;
      wake = 1'h0;
      request = '0;
      repeat (12) @(posedge clock);
      rstn <= 1'h1;
      powerOn();
      wakeUp();
      modeSweep();
      wakeUp();
      pendWake();
      midReset();
      tallyAndFinish();
   end
endmodule
`default_nettype wire
